// ---- design/cfs_pkg.sv ----
// Constants shared by the flag and stack unit of the processor core.
// Assumes a single core clock and an active-low asynchronous reset.
`default_nettype none
package cfs_pkg;
	localparam int FLAG_W = 8;
	localparam int SP_W = 16;
	// Condition-flag field positions, then the half-carry source and sign bits of a result byte.
	localparam int BIT_H = 4;
	localparam int BIT_I = 3;
	localparam int BIT_N = 2;
	localparam int BIT_Z = 1;
	localparam int BIT_C = 0;
	localparam int BIT_HC_SRC = 3;
	localparam int BIT_SIGN = 7;
	// Constant ones in bits 7 to 5 and the mask bit set after reset.
	localparam logic [7:0] FLAG_FIXED = 8'he0;
	localparam logic [7:0] FLAG_RESET = 8'he8;
	// Stack pointer: fixed upper byte, top of stack in the low byte.
	localparam logic [7:0] SP_HIGH = 8'h01;
	localparam logic [7:0] SP_LOW_TOP = 8'hff;
	localparam logic [15:0] SP_RESET = 16'h01ff;
	// Bytes used by a call and by an interrupt frame.
	localparam logic [2:0] CALL_BYTES = 3'h2;
	localparam logic [2:0] IRQ_BYTES = 3'h5;
	// Operations requested of the unit by the instruction sequencer.
	typedef enum logic [3:0] {
		CFS_OP_NONE = 4'h0,
		CFS_OP_ADD = 4'h1,
		CFS_OP_ADC = 4'h2,
		CFS_OP_LOGIC = 4'h3,
		CFS_OP_SHIFT = 4'h4,
		CFS_OP_SCF = 4'h5,
		CFS_OP_RCF = 4'h6,
		CFS_OP_SIM = 4'h7,
		CFS_OP_RIM = 4'h8,
		CFS_OP_FLAG_WR = 4'h9,
		CFS_OP_BTJ = 4'ha
	} cfs_op_t;
	// Stack sequencer states.
	typedef enum logic [3:0] {
		CFS_ST_IDLE = 4'h0,
		CFS_ST_PUSH_PCL = 4'h1,
		CFS_ST_PUSH_PCH = 4'h2,
		CFS_ST_PUSH_X = 4'h3,
		CFS_ST_PUSH_A = 4'h4,
		CFS_ST_PUSH_CC = 4'h5,
		CFS_ST_POP_CC = 4'h6,
		CFS_ST_POP_A = 4'h7,
		CFS_ST_POP_X = 4'h8,
		CFS_ST_POP_PCH = 4'h9,
		CFS_ST_POP_PCL = 4'ha
	} cfs_state_t;
endpackage : cfs_pkg
`default_nettype wire

// ---- design/cfs_alu_flags.sv ----
// Computes the sum, half carry and carry of one add or add with carry.
// Assumes operands and carry-in are stable in the cycle of the request.
`default_nettype none
module cfs_alu_flags (
	input wire logic [7:0] op_a,
	input wire logic [7:0] op_b,
	input wire logic carry_in,
	input wire logic use_carry,
	output logic [7:0] sum,
	output logic half_carry,
	output logic carry_out
);
	import cfs_pkg::*;
	logic [4:0] low_sum;
	logic [8:0] full_sum;
	logic cin;
	// Nibble sum gives the carry from bit 3 into bit 4.
	assign cin = use_carry & carry_in;
	assign low_sum = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
	assign full_sum = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
	assign half_carry = low_sum[4];
	assign sum = full_sum[7:0];
	assign carry_out = full_sum[8];
endmodule : cfs_alu_flags
`default_nettype wire

// ---- design/cfs_irq_latch.sv ----
// Holds pending maskable requests until the mask flag allows service.
// Assumes request lines are synchronous pulses or levels from sources.
`default_nettype none
module cfs_irq_latch (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] irq_req,
	input wire logic [7:0] irq_ack,
	output logic [7:0] irq_pending_q
);
	import cfs_pkg::*;
	logic [7:0] irq_pending_d;
	// A new request wins over an acknowledge in the same cycle.
	assign irq_pending_d = (irq_pending_q & ~irq_ack) | irq_req;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_pending_q <= 8'h00;
		end else begin
			irq_pending_q <= irq_pending_d;
		end
	end
endmodule : cfs_irq_latch
`default_nettype wire

// ---- design/cfs_core.sv ----
// Condition flags and stack pointer of the processor core, with the
// interrupt context save and restore sequencer.
// Assumes the sequencer drives one op per cycle and memory takes a write
// in the cycle stack_we is high; stack_rdata is valid in the pop cycle.
`default_nettype none
module cfs_core (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire cfs_pkg::cfs_op_t op,
	input wire logic [7:0] op_a,
	input wire logic [7:0] op_b,
	input wire logic [7:0] result_in,
	input wire logic shift_carry,
	input wire logic [7:0] flag_wdata,
	input wire logic push_byte,
	input wire logic pop_byte,
	input wire logic call_push,
	input wire logic ret_pop,
	input wire logic sp_reset_instr,
	input wire logic sp_low_we,
	input wire logic [7:0] sp_low_wdata,
	input wire logic [7:0] irq_req,
	input wire logic trap,
	input wire logic return_from_interrupt_instr,
	input wire logic [7:0] program_counter_low,
	input wire logic [7:0] pc_high,
	input wire logic [7:0] index_x,
	input wire logic [7:0] accum,
	input wire logic [7:0] stack_rdata,
	output logic [7:0] condition_flags,
	output logic [15:0] stack_pointer,
	output logic [7:0] alu_sum,
	output logic [15:0] stack_addr,
	output logic stack_we,
	output logic [7:0] stack_wdata,
	output logic ctx_busy,
	output logic irq_enter,
	output logic [2:0] irq_vector,
	output logic [7:0] irq_pending,
	output logic [7:0] rest_pcl,
	output logic [7:0] rest_pch,
	output logic [7:0] rest_x,
	output logic [7:0] rest_a,
	output logic restore_done
);
	import cfs_pkg::*;
	logic [4:0] flags_q;
	logic [4:0] flags_d;
	logic [7:0] sp_low_q;
	logic [7:0] sp_low_d;
	cfs_state_t state_q;
	cfs_state_t state_d;
	logic [7:0] rest_pcl_q;
	logic [7:0] rest_pch_q;
	logic [7:0] rest_x_q;
	logic [7:0] rest_a_q;
	logic restore_done_q;
	logic [7:0] alu_sum_q;
	logic [7:0] sum_w;
	logic hc_w;
	logic co_w;
	logic [7:0] pend_w;
	logic [7:0] ack_w;
	logic [2:0] sel_w;
	logic mask_w;
	logic take_irq;
	logic take_trap;
	logic pushing;
	logic popping;
	logic [7:0] sp_dec;
	logic [7:0] sp_inc;
	logic [7:0] push_data;
	logic is_arith;
	logic is_res;
	logic [7:0] res_w;
	logic irq_enter_q;
	logic [2:0] irq_vector_q;

	// Index of the lowest pending request, used as the priority pick.
	function automatic logic [2:0] cfs_first_set(input logic [7:0] v);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (v[i]) begin
				idx = i[2:0];
			end
		end
		return idx;
	endfunction : cfs_first_set

	// Stack pointer step with silent wrap inside the low byte.
	function automatic logic [7:0] cfs_sp_step(input logic [7:0] s, input logic up);
		return up ? s + 8'h01 : s - 8'h01;
	endfunction : cfs_sp_step

	cfs_alu_flags u_alu (
		.op_a(op_a),
		.op_b(op_b),
		.carry_in(flags_q[BIT_C]),
		.use_carry(op == CFS_OP_ADC),
		.sum(sum_w),
		.half_carry(hc_w),
		.carry_out(co_w)
	);

	cfs_irq_latch u_latch (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.irq_req(irq_req),
		.irq_ack(ack_w),
		.irq_pending_q(pend_w)
	);

	// Entry decision: masked requests wait, the trap never does.
	assign mask_w = flags_q[BIT_I];
	assign take_irq = (state_q == CFS_ST_IDLE) && !mask_w && (pend_w != 8'h00);
	assign take_trap = (state_q == CFS_ST_IDLE) && trap;
	assign sel_w = cfs_first_set(pend_w);
	assign ack_w = (take_irq && !take_trap) ? (8'h01 << sel_w) : 8'h00;

	// Context pushes and pops from the sequencer, plus single-byte traffic.
	assign pushing = (state_q inside {CFS_ST_PUSH_PCL, CFS_ST_PUSH_PCH, CFS_ST_PUSH_X,
		CFS_ST_PUSH_A, CFS_ST_PUSH_CC}) || (state_q == CFS_ST_IDLE && push_byte);
	assign popping = (state_q inside {CFS_ST_POP_CC, CFS_ST_POP_A, CFS_ST_POP_X,
		CFS_ST_POP_PCH, CFS_ST_POP_PCL}) || (state_q == CFS_ST_IDLE && pop_byte);
	assign sp_dec = cfs_sp_step(sp_low_q, 1'b0);
	assign sp_inc = cfs_sp_step(sp_low_q, 1'b1);

	// Push writes at the pointer, pop reads one above it.
	assign stack_addr = {SP_HIGH, popping ? sp_inc : sp_low_q};
	assign stack_we = pushing;
	always_comb begin
		case (state_q)
			CFS_ST_PUSH_PCL: push_data = program_counter_low;
			CFS_ST_PUSH_PCH: push_data = pc_high;
			CFS_ST_PUSH_X: push_data = index_x;
			CFS_ST_PUSH_A: push_data = accum;
			CFS_ST_PUSH_CC: push_data = condition_flags;
			default: push_data = call_push ? program_counter_low : flag_wdata;
		endcase
	end
	assign stack_wdata = push_data;

	// Sequencer: five pushes on entry, five pops in reverse on return.
	always_comb begin
		case (state_q)
			CFS_ST_IDLE: begin
				if (take_trap || take_irq) begin
					state_d = CFS_ST_PUSH_PCL;
				end else if (return_from_interrupt_instr) begin
					state_d = CFS_ST_POP_CC;
				end else begin
					state_d = CFS_ST_IDLE;
				end
			end
			CFS_ST_PUSH_PCL: state_d = CFS_ST_PUSH_PCH;
			CFS_ST_PUSH_PCH: state_d = CFS_ST_PUSH_X;
			CFS_ST_PUSH_X: state_d = CFS_ST_PUSH_A;
			CFS_ST_PUSH_A: state_d = CFS_ST_PUSH_CC;
			CFS_ST_PUSH_CC: state_d = CFS_ST_IDLE;
			CFS_ST_POP_CC: state_d = CFS_ST_POP_A;
			CFS_ST_POP_A: state_d = CFS_ST_POP_X;
			CFS_ST_POP_X: state_d = CFS_ST_POP_PCH;
			CFS_ST_POP_PCH: state_d = CFS_ST_POP_PCL;
			CFS_ST_POP_PCL: state_d = CFS_ST_IDLE;
			default: state_d = CFS_ST_IDLE;
		endcase
	end

	// Stack pointer low byte: reset value, direct load, step per byte.
	always_comb begin
		if (state_q == CFS_ST_IDLE && sp_reset_instr) begin
			sp_low_d = SP_LOW_TOP;
		end else if (state_q == CFS_ST_IDLE && sp_low_we) begin
			sp_low_d = sp_low_wdata;
		end else if (pushing) begin
			sp_low_d = sp_dec;
		end else if (popping) begin
			sp_low_d = sp_inc;
		end else begin
			sp_low_d = sp_low_q;
		end
	end

	// Result flags for arithmetic, logic and shift operations.
	assign is_arith = (op == CFS_OP_ADD) || (op == CFS_OP_ADC);
	assign is_res = is_arith || (op == CFS_OP_LOGIC) || (op == CFS_OP_SHIFT);
	assign res_w = is_arith ? sum_w : result_in;
	always_comb begin
		flags_d = flags_q;
		if (state_q == CFS_ST_POP_CC) begin
			flags_d = stack_rdata[4:0];
		end else if (state_q == CFS_ST_PUSH_CC) begin
			flags_d[BIT_I] = 1'b1;
		end else if (state_q == CFS_ST_IDLE) begin
			if (is_res) begin
				flags_d[BIT_N] = res_w[BIT_SIGN];
				flags_d[BIT_Z] = (res_w == 8'h00);
			end
			if (is_arith) begin
				flags_d[BIT_H] = hc_w;
				flags_d[BIT_C] = co_w;
			end
			case (op)
				CFS_OP_SHIFT: flags_d[BIT_C] = shift_carry;
				CFS_OP_BTJ: flags_d[BIT_C] = shift_carry;
				CFS_OP_SCF: flags_d[BIT_C] = 1'b1;
				CFS_OP_RCF: flags_d[BIT_C] = 1'b0;
				CFS_OP_SIM: flags_d[BIT_I] = 1'b1;
				CFS_OP_RIM: flags_d[BIT_I] = 1'b0;
				CFS_OP_FLAG_WR: flags_d = flag_wdata[4:0];
				default: flags_d = flags_d;
			endcase
			if (pop_byte && op == CFS_OP_FLAG_WR) begin
				flags_d = stack_rdata[4:0];
			end
		end
	end

	// Flag, pointer and sequencer registers.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flags_q <= FLAG_RESET[4:0];
			sp_low_q <= SP_LOW_TOP;
			state_q <= CFS_ST_IDLE;
		end else begin
			flags_q <= flags_d;
			sp_low_q <= sp_low_d;
			state_q <= state_d;
		end
	end

	// Captured context bytes on return, and entry strobe.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rest_pcl_q <= 8'h00;
			rest_pch_q <= 8'h00;
			rest_x_q <= 8'h00;
			rest_a_q <= 8'h00;
			restore_done_q <= 1'b0;
			irq_enter_q <= 1'b0;
			irq_vector_q <= 3'h0;
			alu_sum_q <= 8'h00;
		end else begin
			if (state_q == CFS_ST_POP_A) rest_a_q <= stack_rdata;
			if (state_q == CFS_ST_POP_X) rest_x_q <= stack_rdata;
			if (state_q == CFS_ST_POP_PCH) rest_pch_q <= stack_rdata;
			if (state_q == CFS_ST_POP_PCL) rest_pcl_q <= stack_rdata;
			restore_done_q <= (state_q == CFS_ST_POP_PCL);
			irq_enter_q <= take_trap || take_irq;
			if (take_irq && !take_trap) irq_vector_q <= sel_w;
			if (is_arith) alu_sum_q <= sum_w;
		end
	end

	// Upper pointer byte is constant; fixed flag bits are constant ones.
	assign stack_pointer = {SP_HIGH, sp_low_q};
	assign condition_flags = FLAG_FIXED | {3'h0, flags_q};
	assign ctx_busy = (state_q != CFS_ST_IDLE);
	assign irq_enter = irq_enter_q;
	assign irq_vector = irq_vector_q;
	assign irq_pending = pend_w;
	assign rest_pcl = rest_pcl_q;
	assign rest_pch = rest_pch_q;
	assign rest_x = rest_x_q;
	assign rest_a = rest_a_q;
	assign restore_done = restore_done_q;
	assign alu_sum = alu_sum_q;

	// Bound on the frame: entry decrements the pointer by five.
	property p_irq_frame;
		@(posedge clk_sys) disable iff (!rst_n)
		(state_q == CFS_ST_IDLE && (take_irq || take_trap) && !sp_reset_instr)
			|=> ##4 (sp_low_d == $past(sp_low_q, 5) - {5'h00, IRQ_BYTES});
	endproperty
	a_irq_frame: assert property (p_irq_frame) else $error("frame size wrong");

	property p_pcl_first;
		@(posedge clk_sys) disable iff (!rst_n)
		(state_q == CFS_ST_PUSH_PCL) |-> (stack_we && stack_wdata == program_counter_low);
	endproperty
	a_pcl_first: assert property (p_pcl_first) else $error("pcl not first");

	property p_mask_on_entry;
		@(posedge clk_sys) disable iff (!rst_n)
		(state_q == CFS_ST_PUSH_CC) |=> condition_flags[BIT_I];
	endproperty
	a_mask_on_entry: assert property (p_mask_on_entry) else $error("mask not set");

	property p_fixed_ones;
		@(posedge clk_sys) disable iff (!rst_n)
		condition_flags[7:5] == 3'h7 && stack_pointer[15:8] == SP_HIGH;
	endproperty
	a_fixed_ones: assert property (p_fixed_ones) else $error("fixed bits lost");

	property p_masked_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(mask_w && !trap && state_q == CFS_ST_IDLE) |=> !(state_q == CFS_ST_PUSH_PCL);
	endproperty
	a_masked_hold: assert property (p_masked_hold) else $error("masked irq taken");

	property p_trap_any;
		@(posedge clk_sys) disable iff (!rst_n)
		take_trap |=> (state_q == CFS_ST_PUSH_PCL) ##1 (state_q == CFS_ST_PUSH_PCH);
	endproperty
	a_trap_any: assert property (p_trap_any) else $error("trap not entered");

	property p_wrap;
		@(posedge clk_sys) disable iff (!rst_n)
		(state_q == CFS_ST_IDLE && push_byte && !sp_reset_instr && !sp_low_we
			&& sp_low_q == 8'h00) |=> (sp_low_q == 8'hff);
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap");

	property p_zero_neg;
		@(posedge clk_sys) disable iff (!rst_n)
		(state_q == CFS_ST_IDLE && is_arith)
			|=> (condition_flags[BIT_Z] == (alu_sum == 8'h00)
			&& condition_flags[BIT_N] == alu_sum[7]);
	endproperty
	a_zero_neg: assert property (p_zero_neg) else $error("n or z wrong");
endmodule : cfs_core
`default_nettype wire

// ---- dv/tb.sv ----
// Self-checking bench for the flag and stack unit of the processor core.
// Assumes the cfs_core header and cfs_pkg constants; the bench models stack memory.
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cfs_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	cfs_op_t op = CFS_OP_NONE;
	logic [7:0] op_a = 8'h00, op_b = 8'h00, flag_wdata = 8'h00, sp_low_wdata = 8'h00;
	logic [7:0] irq_req = 8'h00, stack_rdata;
	logic push_byte = 1'b0, pop_byte = 1'b0, sp_reset_instr = 1'b0, sp_low_we = 1'b0;
	logic call_push = 1'b0;
	logic trap = 1'b0, return_from_interrupt_instr = 1'b0;
	logic [7:0] condition_flags, alu_sum, stack_wdata, irq_pending;
	logic [15:0] stack_pointer, stack_addr;
	logic stack_we, ctx_busy, irq_enter, restore_done;
	logic [2:0] irq_vector;
	logic [7:0] rest_pcl, rest_pch, rest_x, rest_a;
	logic [7:0] mem [256];
	int n_fail = 0;
	int n_checks = 0;

	// Clock at 40 ns period.
	always #20 clk_sys = ~clk_sys;

	// Stack memory: written when the unit strobes, read combinationally.
	assign stack_rdata = mem[stack_addr[7:0]];
	always @(posedge clk_sys) begin
		if (stack_we === 1'b1) mem[stack_addr[7:0]] <= stack_wdata;
	end

	cfs_core i_cfs_core (.clk_sys(clk_sys), .rst_n(rst_n), .op(op), .op_a(op_a), .op_b(op_b),
		.result_in(op_a), .shift_carry(op_b[0]), .flag_wdata(flag_wdata),
		.push_byte(push_byte), .pop_byte(pop_byte), .call_push(call_push), .ret_pop(1'b0),
		.sp_reset_instr(sp_reset_instr), .sp_low_we(sp_low_we), .sp_low_wdata(sp_low_wdata),
		.irq_req(irq_req), .trap(trap), .return_from_interrupt_instr(return_from_interrupt_instr),
		.program_counter_low(8'ha1), .pc_high(8'hb2), .index_x(8'hc3), .accum(8'hd4),
		.stack_rdata(stack_rdata), .condition_flags(condition_flags),
		.stack_pointer(stack_pointer), .alu_sum(alu_sum), .stack_addr(stack_addr),
		.stack_we(stack_we), .stack_wdata(stack_wdata), .ctx_busy(ctx_busy),
		.irq_enter(irq_enter), .irq_vector(irq_vector), .irq_pending(irq_pending),
		.rest_pcl(rest_pcl), .rest_pch(rest_pch), .rest_x(rest_x), .rest_a(rest_a),
		.restore_done(restore_done));

	// Prints the counts and the verdict, then stops the run.
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	// Compares one byte result.
	task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp8

	// Compares one word result.
	task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp16

	// Raises a request at a rising edge and stops at the following falling edge.
	task automatic go(input cfs_op_t o, input logic [7:0] a, input logic [7:0] b,
		input logic pu, input logic po, input logic sw, input logic [7:0] d);
		@(posedge clk_sys);
		op <= o;
		op_a <= a;
		op_b <= b;
		push_byte <= pu;
		pop_byte <= po;
		sp_low_we <= sw;
		sp_low_wdata <= d;
		flag_wdata <= d;
		@(negedge clk_sys);
	endtask : go

	// Releases every request except call_push after the taking edge, so registers are settled.
	task automatic done;
		@(posedge clk_sys);
		op <= CFS_OP_NONE;
		push_byte <= 1'b0;
		pop_byte <= 1'b0;
		sp_low_we <= 1'b0;
		sp_reset_instr <= 1'b0;
		irq_req <= 8'h00;
		trap <= 1'b0;
		return_from_interrupt_instr <= 1'b0;
		@(negedge clk_sys);
	endtask : done

	// One flag operation followed by a flag compare.
	task automatic op1(input cfs_op_t o, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] e);
		go(o, a, b, 1'b0, 1'b0, 1'b0, a);
		done();
		cmp8("flags", e, condition_flags);
	endtask : op1

	// Waits for a context frame and checks its five writes in order.
	task automatic frame(input logic [15:0] top, input logic [7:0] cc);
		logic [7:0] ctx [5];
		int i;
		ctx = '{8'ha1, 8'hb2, 8'hc3, 8'hd4, cc};
		for (i = 0; i < 20 && stack_we !== 1'b1; i++) @(negedge clk_sys);
		if (i == 20) begin
			n_fail++;
			end_of_test();
		end
		cmp8("enter", 8'h01, {7'h0, irq_enter});
		for (i = 0; i < 5; i++) begin
			cmp16("frame_addr", top - 16'(i), stack_addr);
			cmp8("frame_data", ctx[i], stack_wdata);
			cmp8("frame_we", 8'h01, {7'h0, stack_we});
			@(negedge clk_sys);
		end
		cmp8("frame_end", 8'h00, {7'h0, stack_we});
	endtask : frame

	// Arithmetic flags from add and add with carry.
	task automatic t_alu;
		op1(CFS_OP_ADD, 8'h0f, 8'h01, 8'hf8);
		cmp8("sum", 8'h10, alu_sum);
		op1(CFS_OP_ADD, 8'h80, 8'h80, 8'heb);
		op1(CFS_OP_ADC, 8'h7f, 8'h00, 8'hfc);
	endtask : t_alu

	// Carry and mask instructions, whole writes, logic and shift results.
	task automatic t_flags;
		op1(CFS_OP_SCF, 8'h00, 8'h00, 8'hfd);
		op1(CFS_OP_RCF, 8'h00, 8'h00, 8'hfc);
		op1(CFS_OP_RIM, 8'h00, 8'h00, 8'hf4);
		op1(CFS_OP_SIM, 8'h00, 8'h00, 8'hfc);
		op1(CFS_OP_FLAG_WR, 8'h00, 8'h00, 8'he0);
		op1(CFS_OP_FLAG_WR, 8'h1f, 8'h00, 8'hff);
		go(CFS_OP_LOGIC, 8'h80, 8'h00, 1'b0, 1'b0, 1'b0, 8'h80);
		done();
		cmp8("nz", 8'h02, {6'h0, condition_flags[2:1]});
		go(CFS_OP_LOGIC, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
		done();
		cmp8("nz", 8'h01, {6'h0, condition_flags[2:1]});
		op1(CFS_OP_FLAG_WR, 8'h00, 8'h00, 8'he0);
		go(CFS_OP_SHIFT, 8'h00, 8'h01, 1'b0, 1'b0, 1'b0, 8'h00);
		done();
		cmp8("carry", 8'h01, {7'h0, condition_flags[0]});
		op1(CFS_OP_FLAG_WR, 8'h08, 8'h00, 8'he8);
	endtask : t_flags

	// Single pushes and pops, direct load, wrap both ways, pointer reset.
	task automatic t_stack;
		go(CFS_OP_NONE, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 8'h5a);
		cmp16("push_addr", 16'h01ff, stack_addr);
		cmp8("push_data", 8'h5a, stack_wdata);
		done();
		cmp16("sp", 16'h01fe, stack_pointer);
		go(CFS_OP_NONE, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0, 8'h00);
		cmp16("pop_addr", 16'h01ff, stack_addr);
		done();
		cmp16("sp", 16'h01ff, stack_pointer);
		go(CFS_OP_NONE, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1, 8'h00);
		done();
		cmp16("sp", 16'h0100, stack_pointer);
		go(CFS_OP_NONE, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0, 8'h3c);
		cmp16("push_addr", 16'h0100, stack_addr);
		done();
		cmp16("sp", 16'h01ff, stack_pointer);
		go(CFS_OP_NONE, 8'h00, 8'h00, 1'b0, 1'b1, 1'b0, 8'h00);
		cmp16("pop_addr", 16'h0100, stack_addr);
		done();
		cmp16("sp", 16'h0100, stack_pointer);
		// A call is two pushes: the low counter byte first, then the high byte.
		@(posedge clk_sys);
		call_push <= 1'b1;
		push_byte <= 1'b1;
		@(negedge clk_sys);
		cmp8("call_pcl", 8'ha1, stack_wdata);
		@(posedge clk_sys);
		call_push <= 1'b0;
		flag_wdata <= 8'hb2;
		@(negedge clk_sys);
		cmp8("call_pch", 8'hb2, stack_wdata);
		done();
		cmp16("sp", 16'h01fe, stack_pointer);
		@(posedge clk_sys);
		sp_reset_instr <= 1'b1;
		done();
		cmp16("sp", 16'h01ff, stack_pointer);
	endtask : t_stack

	// Masked latch, entry on clear, nested entry, return and trap.
	task automatic t_irq;
		int i;
		@(posedge clk_sys);
		irq_req <= 8'h04;
		done();
		for (i = 0; i < 6; i++) begin
			cmp8("busy", 8'h00, {7'h0, ctx_busy});
			@(negedge clk_sys);
		end
		cmp8("pending", 8'h01, {7'h0, irq_pending[2]});
		go(CFS_OP_RIM, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
		done();
		frame(16'h01ff, 8'he0);
		cmp8("flags", 8'he8, condition_flags);
		cmp16("sp", 16'h01fa, stack_pointer);
		cmp8("vector", 8'h02, {5'h0, irq_vector});
		@(posedge clk_sys);
		irq_req <= 8'h01;
		done();
		go(CFS_OP_RIM, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, 8'h00);
		done();
		frame(16'h01fa, 8'he0);
		cmp8("vector", 8'h00, {5'h0, irq_vector});
		@(posedge clk_sys);
		return_from_interrupt_instr <= 1'b1;
		done();
		for (i = 0; i < 20 && restore_done !== 1'b1; i++) @(negedge clk_sys);
		if (i == 20) begin
			n_fail++;
			end_of_test();
		end
		cmp8("rest_pcl", 8'ha1, rest_pcl);
		cmp8("rest_pch", 8'hb2, rest_pch);
		cmp8("rest_x", 8'hc3, rest_x);
		cmp8("rest_a", 8'hd4, rest_a);
		@(negedge clk_sys);
		cmp8("flags", 8'he0, condition_flags);
		cmp16("sp", 16'h01fa, stack_pointer);
		op1(CFS_OP_SIM, 8'h00, 8'h00, 8'he8);
		@(posedge clk_sys);
		trap <= 1'b1;
		done();
		frame(16'h01fa, 8'he8);
		cmp16("sp", 16'h01f5, stack_pointer);
	endtask : t_irq

	// Main sequence: reset, then each scenario in turn.
	initial begin
		foreach (mem[k]) mem[k] = 8'h00;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(negedge clk_sys);
		cmp8("flags", 8'he8, condition_flags);
		cmp16("sp", 16'h01ff, stack_pointer);
		t_alu();
		t_flags();
		t_stack();
		t_irq();
		end_of_test();
	end
endmodule : tb
`default_nettype wire
